// file: logic/nv_program_write_protect.sv
`timescale 1ns/1ns
// Notes on behaviour
// RL1: Protect command is immediate code 33 with two 16-bit parameters.
// RL2: Addresses below first-writable address are protected user space.
// RL3: First-writable zero removes user protection and clears stored lockout code.
// RL4: First-writable 65535 locks whole user space.
// RL5: Writes in protected space refused, register saves too; others proceed.
// RL6: Factory region starts 0xF800 on one grade, 0xFF00 otherwise.
// RL7: On unprotected-factory grade, any protect command enables factory protection.
// RL8: Both parameters zero only enables factory protection.
// RL9: Busy device answers busy NAK and does nothing.
// RL10: Wrong lockout code gives NAK code 9, protection unchanged.
// RL11: Store program into protected region gets bad-code NAK, no write.
// RL12: Register save into protected space sets status bits 14 and 12, stops program.
// RL13: Host must unprotect with matching code before downloading.
// RL14: Settings persist in nonvolatile storage; success returns plain ACK.
// RL15: With no user protection, any lockout code is accepted and stored.
`include "nvwp_regs.svh"
module nv_program_write_protect #(
  parameter bit HIGH_GRADE = 1'b0
) (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        restore_in,
  input  wire logic [15:0] restore_code_in,
  input  wire logic [15:0] restore_addr_in,
  input  wire logic        restore_fact_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_num_in,
  input  wire logic [15:0] cmd_code_in,
  input  wire logic [15:0] cmd_addr_in,
  input  wire logic        busy_in,
  output logic             rsp_valid_out,
  output logic [1:0]       rsp_kind_out,
  output logic [7:0]       rsp_nak_code_out,
  output logic             persist_out,
  output logic [15:0]      persist_code_out,
  output logic [15:0]      persist_addr_out,
  output logic             persist_fact_out,
  input  wire logic        wr_req_in,
  input  wire logic [1:0]  wr_kind_in,
  input  wire logic [15:0] wr_addr_in,
  output logic             wr_grant_out,
  output logic             wr_refuse_out,
  output logic             store_nak_out,
  output logic             prog_exit_out,
  output logic [15:0]      status_set_out,
  output logic [15:0]      first_wr_out,
  output logic             fact_prot_out
);
  logic [15:0] code_s, addr_s, fact_base;
  logic        fact_s, blocked;
  logic        mem_wr;
  logic [15:0] new_code, new_addr;
  logic        new_fact;
  logic        rsp_valid_q, rsp_valid_d;
  logic [1:0]  rsp_kind_q, rsp_kind_d;
  logic [7:0]  nak_q, nak_d;
  logic        grant_q, grant_d, refuse_q, refuse_d, snak_q, snak_d, exit_q, exit_d;
  logic [15:0] stat_q, stat_d;
  logic        is_cmd;
  // Persist strobe and data leave from flops so the storage side sees clean values
  logic        pers_q, pers_fact_q;
  logic [15:0] pers_code_q, pers_addr_q;

  assign fact_base = HIGH_GRADE ? `NVWP_FACT_BASE_HI_GRADE : `NVWP_FACT_BASE_LO_GRADE; // RL6

  nvwp_state_mem u_mem (
    .clock_in     (clock_in),
    .srst_in      (srst_in),
    .load_in      (restore_in),
    .load_code_in (restore_code_in),
    .load_addr_in (restore_addr_in),
    .load_fact_in (restore_fact_in),
    .wr_in        (mem_wr),
    .wr_code_in   (new_code),
    .wr_addr_in   (new_addr),
    .wr_fact_in   (new_fact),
    .code_out     (code_s),
    .addr_out     (addr_s),
    .fact_out     (fact_s)
  );

  nvwp_wr_check u_chk (
    .addr_in      (wr_addr_in),
    .first_wr_in  (addr_s),
    .fact_on_in   (fact_s),
    .fact_base_in (fact_base),
    .blocked_out  (blocked)
  );

  assign is_cmd = cmd_valid_in && (cmd_num_in == `NVWP_CMD_PROTECT); // RL1

  // Zero first-writable address means no user space is protected, so any code passes
  function automatic logic user_open(input logic [15:0] first_wr);
    user_open = (first_wr == `NVWP_ADDR_NONE);
  endfunction

  function automatic logic code_ok(input logic [15:0] first_wr, input logic [15:0] stored,
                                   input logic [15:0] given);
    code_ok = user_open(first_wr) || (given == stored);
  endfunction

  // Command path
  always_comb begin
    mem_wr      = 1'b0;
    new_code    = code_s;
    new_addr    = addr_s;
    new_fact    = fact_s;
    rsp_valid_d = 1'b0;
    rsp_kind_d  = rsp_kind_q;
    nak_d       = nak_q;
    if (is_cmd && !restore_in) begin
      rsp_valid_d = 1'b1;
      if (busy_in) begin
        rsp_kind_d = nvwp_pkg::NVWP_RSP_NAK_BUSY; // RL9
        nak_d      = 8'h00;
      end else if (!code_ok(addr_s, code_s, cmd_code_in)) begin
        rsp_kind_d = nvwp_pkg::NVWP_RSP_NAK_CODE; // RL10
        nak_d      = `NVWP_NAK_BAD_CODE;
      end else begin
        // Code accepted freely while user space is open
        mem_wr     = 1'b1; // RL15 RL14
        new_fact   = 1'b1; // RL7
        rsp_kind_d = nvwp_pkg::NVWP_RSP_ACK; // RL14
        nak_d      = 8'h00;
        if (cmd_code_in == 16'h0000 && cmd_addr_in == `NVWP_ADDR_NONE) begin
          new_code = code_s; // RL8
          new_addr = addr_s;
        end else if (cmd_addr_in == `NVWP_ADDR_NONE) begin
          new_code = 16'h0000; // RL3
          new_addr = `NVWP_ADDR_NONE;
        end else begin
          new_code = cmd_code_in; // RL2 RL4
          new_addr = cmd_addr_in;
        end
      end
    end
  end

  // Write-guard path
  always_comb begin
    grant_d  = 1'b0;
    refuse_d = 1'b0;
    snak_d   = 1'b0;
    exit_d   = 1'b0;
    stat_d   = 16'h0000;
    if (wr_req_in) begin
      if (!blocked) begin
        grant_d = 1'b1; // RL5
      end else begin
        refuse_d = 1'b1; // RL5
        unique case (wr_kind_in)
          nvwp_pkg::NVWP_WR_STORE: snak_d = 1'b1; // RL11
          nvwp_pkg::NVWP_WR_REGSAVE: begin
            exit_d = 1'b1; // RL12
            stat_d[`NVWP_STAT_BIT_A] = 1'b1;
            stat_d[`NVWP_STAT_BIT_B] = 1'b1;
          end
          default: snak_d = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rsp_valid_q <= 1'b0;
      rsp_kind_q  <= 2'b00;
      nak_q       <= 8'h00;
      grant_q     <= 1'b0;
      refuse_q    <= 1'b0;
      snak_q      <= 1'b0;
      exit_q      <= 1'b0;
      stat_q      <= 16'h0000;
      pers_q      <= 1'b0;
      pers_code_q <= 16'h0000;
      pers_addr_q <= 16'h0000;
      pers_fact_q <= 1'b0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_kind_q  <= rsp_kind_d;
      nak_q       <= nak_d;
      grant_q     <= grant_d;
      refuse_q    <= refuse_d;
      snak_q      <= snak_d;
      exit_q      <= exit_d;
      stat_q      <= stat_d;
      pers_q      <= mem_wr; // RL14
      pers_code_q <= new_code;
      pers_addr_q <= new_addr;
      pers_fact_q <= new_fact;
    end
  end

  assign rsp_valid_out    = rsp_valid_q;
  assign rsp_kind_out     = rsp_kind_q;
  assign rsp_nak_code_out = nak_q;
  assign persist_out      = pers_q;
  assign persist_code_out = pers_code_q;
  assign persist_addr_out = pers_addr_q;
  assign persist_fact_out = pers_fact_q;
  assign wr_grant_out     = grant_q;
  assign wr_refuse_out    = refuse_q;
  assign store_nak_out    = snak_q;
  assign prog_exit_out    = exit_q;
  assign status_set_out   = stat_q;
  assign first_wr_out     = addr_s;
  assign fact_prot_out    = fact_s;

  a_busy_nak: assert property (@(posedge clock_in) disable iff (srst_in) // RL9
    (is_cmd && busy_in && !restore_in) |=> (rsp_valid_out &&
      rsp_kind_out == nvwp_pkg::NVWP_RSP_NAK_BUSY && $stable(first_wr_out)))
    else $error("busy command not refused");
  a_bad_code: assert property (@(posedge clock_in) disable iff (srst_in) // RL10
    (is_cmd && !busy_in && !restore_in && addr_s != 16'h0000 && cmd_code_in != code_s)
      |=> (rsp_nak_code_out == 8'h09 && $stable(first_wr_out)))
    else $error("bad lockout code not refused");
  a_clear_all: assert property (@(posedge clock_in) disable iff (srst_in) // RL3
    (mem_wr && !restore_in && cmd_addr_in == 16'h0000 && cmd_code_in != 16'h0000)
      |=> (first_wr_out == 16'h0000 && u_mem.code_out == 16'h0000))
    else $error("unprotect failed");
  a_fact_on: assert property (@(posedge clock_in) disable iff (srst_in) // RL7
    (mem_wr && !restore_in) |=> fact_prot_out)
    else $error("factory protection not enabled");
  a_zero_keep: assert property (@(posedge clock_in) disable iff (srst_in) // RL8
    (mem_wr && !restore_in && cmd_addr_in == 16'h0000 && cmd_code_in == 16'h0000)
      |=> $stable(first_wr_out))
    else $error("zero command changed user space");
  a_low_refused: assert property (@(posedge clock_in) disable iff (srst_in) // RL2
    (wr_req_in && wr_addr_in < addr_s) |=> (wr_refuse_out && !wr_grant_out))
    else $error("protected write granted");
  a_lock_all: assert property (@(posedge clock_in) disable iff (srst_in) // RL4
    (wr_req_in && addr_s == 16'hFFFF) |=> wr_refuse_out)
    else $error("full lock leaked");
  a_regsave_stat: assert property (@(posedge clock_in) disable iff (srst_in) // RL12
    (wr_req_in && blocked && wr_kind_in == 2'b01)
      |=> (status_set_out == 16'h5000 && prog_exit_out))
    else $error("register save status wrong");
  a_store_nak: assert property (@(posedge clock_in) disable iff (srst_in) // RL11
    (wr_req_in && blocked && wr_kind_in == 2'b10) |=> (store_nak_out && !wr_grant_out))
    else $error("store not refused");

  // Building blocks for the command and write handshake checks
  sequence s_cmd_ok;
    is_cmd && !restore_in && !busy_in && code_ok(addr_s, code_s, cmd_code_in);
  endsequence
  sequence s_cmd_bad;
    is_cmd && !restore_in && !busy_in && !code_ok(addr_s, code_s, cmd_code_in);
  endsequence
  sequence s_acked;
    rsp_valid_out && rsp_kind_out == 2'b00 && rsp_nak_code_out == 8'h00 && persist_out;
  endsequence
  sequence s_wr_open;
    wr_req_in && wr_addr_in >= addr_s && addr_s != 16'hFFFF;
  endsequence

  a_ack_plain: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
    s_cmd_ok |=> s_acked)
    else $error("accepted command not acknowledged");
  a_persist_same: assert property (@(posedge clock_in) disable iff (srst_in) // RL14
    s_cmd_ok |=> (persist_addr_out == first_wr_out && persist_code_out == u_mem.code_out &&
      persist_fact_out == fact_prot_out))
    else $error("persisted settings differ from live ones");
  a_set_addr: assert property (@(posedge clock_in) disable iff (srst_in) // RL2
    s_cmd_ok ##0 (cmd_addr_in != 16'h0000) |=> first_wr_out == $past(cmd_addr_in))
    else $error("first writable address not taken");
  a_open_code: assert property (@(posedge clock_in) disable iff (srst_in) // RL15
    s_cmd_ok ##0 (user_open(addr_s) && cmd_addr_in != 16'h0000)
      |=> u_mem.code_out == $past(cmd_code_in))
    else $error("open space did not take new code");
  a_bad_kind: assert property (@(posedge clock_in) disable iff (srst_in) // RL10
    s_cmd_bad |=> (rsp_valid_out && rsp_kind_out == 2'b10 && !persist_out))
    else $error("bad code command not refused");
  a_busy_still: assert property (@(posedge clock_in) disable iff (srst_in) // RL9
    (is_cmd && busy_in && !restore_in) |=> (!persist_out && $stable(fact_prot_out)))
    else $error("busy command was carried out");
  a_busy_nocode: assert property (@(posedge clock_in) disable iff (srst_in) // RL9
    (is_cmd && busy_in && !restore_in) |=> (rsp_nak_code_out == 8'h00))
    else $error("busy refusal carried an error code");
  a_other_cmd: assert property (@(posedge clock_in) disable iff (srst_in) // RL1
    (cmd_valid_in && cmd_num_in != 8'h21 && !restore_in)
      |=> (!rsp_valid_out && !persist_out && $stable(first_wr_out)))
    else $error("foreign command acted on");
  a_high_grant: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
    s_wr_open ##0 (!(fact_s && wr_addr_in >= fact_base)) |=> (wr_grant_out && !wr_refuse_out))
    else $error("open write refused");
  a_store_open: assert property (@(posedge clock_in) disable iff (srst_in) // RL11
    s_wr_open ##0 (wr_kind_in == 2'b10 && wr_addr_in < 16'hF800)
      |=> (wr_grant_out && !store_nak_out))
    else $error("open store refused");
  a_fact_block: assert property (@(posedge clock_in) disable iff (srst_in) // RL6
    (wr_req_in && fact_s && wr_addr_in >= (HIGH_GRADE ? 16'hF800 : 16'hFF00))
      |=> (wr_refuse_out && !wr_grant_out))
    else $error("factory region write granted");
  a_one_answer: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
    wr_req_in |=> (wr_grant_out != wr_refuse_out))
    else $error("write answer not exactly one of grant and refuse");
  a_idle_quiet: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
    !wr_req_in |=> (!wr_grant_out && !wr_refuse_out && !store_nak_out && !prog_exit_out &&
      status_set_out == 16'h0000))
    else $error("write answer without request");
  a_data_plain: assert property (@(posedge clock_in) disable iff (srst_in) // RL5
    (wr_req_in && wr_kind_in == 2'b00) |=> (!store_nak_out && !prog_exit_out &&
      status_set_out == 16'h0000))
    else $error("data write raised program outcome");
endmodule

// file: logic/nvwp_pkg.sv
package nvwp_pkg;
  typedef enum logic [1:0] {
    NVWP_RSP_ACK      = 2'b00,
    NVWP_RSP_NAK_BUSY = 2'b01,
    NVWP_RSP_NAK_CODE = 2'b10
  } nvwp_rsp_e;
  typedef enum logic [1:0] {
    NVWP_WR_DATA = 2'b00,
    NVWP_WR_REGSAVE = 2'b01,
    NVWP_WR_STORE = 2'b10
  } nvwp_wr_e;
endpackage

// file: logic/nvwp_regs.svh
`ifndef NVWP_REGS_SVH
`define NVWP_REGS_SVH
`define NVWP_CMD_PROTECT        8'h21
`define NVWP_ADDR_NONE          16'h0000
`define NVWP_ADDR_ALL           16'hFFFF
`define NVWP_FACT_BASE_HI_GRADE 16'hF800
`define NVWP_FACT_BASE_LO_GRADE 16'hFF00
`define NVWP_NAK_BAD_CODE       8'h09
`define NVWP_STAT_BIT_A         14
`define NVWP_STAT_BIT_B         12
`endif

// file: logic/nvwp_state_mem.sv
`timescale 1ns/1ns
// Nonvolatile-backed protection settings; restored value loaded after reset
module nvwp_state_mem (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        load_in,
  input  wire logic [15:0] load_code_in,
  input  wire logic [15:0] load_addr_in,
  input  wire logic        load_fact_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] wr_code_in,
  input  wire logic [15:0] wr_addr_in,
  input  wire logic        wr_fact_in,
  output logic      [15:0] code_out,
  output logic      [15:0] addr_out,
  output logic             fact_out
);
  logic [15:0] code_q, code_d, addr_q, addr_d;
  logic        fact_q, fact_d;
  always_comb begin
    code_d = code_q;
    addr_d = addr_q;
    fact_d = fact_q;
    if (load_in) begin
      code_d = load_code_in;
      addr_d = load_addr_in;
      fact_d = load_fact_in;
    end else if (wr_in) begin
      code_d = wr_code_in;
      addr_d = wr_addr_in;
      fact_d = wr_fact_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      code_q <= 16'h0000;
      addr_q <= 16'h0000;
      fact_q <= 1'b0;
    end else begin
      code_q <= code_d;
      addr_q <= addr_d;
      fact_q <= fact_d;
    end
  end
  assign code_out = code_q;
  assign addr_out = addr_q;
  assign fact_out = fact_q;
endmodule

// file: logic/nvwp_wr_check.sv
`timescale 1ns/1ns
`include "nvwp_regs.svh"
// Pure address decode shared by every write kind
module nvwp_wr_check (
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] first_wr_in,
  input  wire logic        fact_on_in,
  input  wire logic [15:0] fact_base_in,
  output logic             blocked_out
);
  function automatic logic in_user(input logic [15:0] a, input logic [15:0] f);
    // 0xFFFF locks all user space, even the top address itself
    in_user = (f == `NVWP_ADDR_ALL) ? 1'b1 : (a < f);
  endfunction
  assign blocked_out = in_user(addr_in, first_wr_in) ||
                       (fact_on_in && (addr_in >= fact_base_in));
endmodule

// file: tb/nvwp_host.sv
`timescale 1ns/1ns
// Host on the serial command channel
module nvwp_host (
  input  wire logic  clock_in,
  output logic       cmd_valid_out = 1'b0,
  output logic [7:0] cmd_num_out = 8'h00,
  output logic [15:0] cmd_code_out = 16'h0000,
  output logic [15:0] cmd_addr_out = 16'h0000,
  output logic       wr_req_out = 1'b0,
  output logic [1:0] wr_kind_out = 2'h0,
  output logic [15:0] wr_addr_out = 16'h0000
);
  task automatic start_cmd(input logic [7:0] n, input logic [15:0] c, input logic [15:0] a);
    @(posedge clock_in) #1;
    cmd_valid_out = 1'b1;
    cmd_num_out = n;
    cmd_code_out = c;
    cmd_addr_out = a;
  endtask
  // Released fields go inverted, so a stale value never passes
  task automatic end_cmd();
    @(posedge clock_in) #1;
    cmd_valid_out = 1'b0;
    cmd_num_out = ~cmd_num_out;
    cmd_code_out = ~cmd_code_out;
    cmd_addr_out = ~cmd_addr_out;
  endtask
  task automatic send_wr(input logic [1:0] k, input logic [15:0] a);
    @(posedge clock_in) #1;
    wr_req_out = 1'b1;
    wr_kind_out = k;
    wr_addr_out = a;
    @(posedge clock_in) #1;
    wr_req_out = 1'b0;
    wr_addr_out = ~a;
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        restore_in = 1'b0;
  logic        restore_fact_in = 1'b0;
  logic        busy_in = 1'b0;
  logic [15:0] restore_code_in = 16'h0000, restore_addr_in = 16'h0000;
  logic        cmd_valid_in, wr_req_in;
  logic [7:0]  cmd_num_in;
  logic [15:0] cmd_code_in, cmd_addr_in, wr_addr_in;
  logic [1:0]  wr_kind_in, rsp_kind_out;
  logic        rsp_valid_out, persist_out, persist_fact_out, fact_prot_out;
  logic        wr_grant_out, wr_refuse_out, store_nak_out, prog_exit_out;
  logic [7:0]  rsp_nak_code_out;
  logic [15:0] persist_code_out, persist_addr_out, status_set_out, first_wr_out;
  int          err_count = 0;
  int          n_compared = 0;
  always #4 clock_in = ~clock_in;
  nvwp_host host_u (.clock_in, .cmd_valid_out(cmd_valid_in), .cmd_num_out(cmd_num_in),
    .cmd_code_out(cmd_code_in), .cmd_addr_out(cmd_addr_in), .wr_req_out(wr_req_in),
    .wr_kind_out(wr_kind_in), .wr_addr_out(wr_addr_in));
  nv_program_write_protect #(.HIGH_GRADE(1'b0)) dut_u (.clock_in, .srst_in, .restore_in,
    .restore_code_in, .restore_addr_in, .restore_fact_in, .cmd_valid_in, .cmd_num_in,
    .cmd_code_in, .cmd_addr_in, .busy_in, .rsp_valid_out, .rsp_kind_out, .rsp_nak_code_out,
    .persist_out, .persist_code_out, .persist_addr_out, .persist_fact_out, .wr_req_in,
    .wr_kind_in, .wr_addr_in, .wr_grant_out, .wr_refuse_out, .store_nak_out, .prog_exit_out,
    .status_set_out, .first_wr_out, .fact_prot_out);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // rsp is {valid, kind}: 4 ack, 5 busy, 6 bad code
  task automatic cmd(input logic [15:0] c, input logic [15:0] a, input logic [2:0] rsp);
    host_u.start_cmd(8'h21, c, a);
    host_u.end_cmd();
    chk("rsp", {13'h0, rsp}, {13'h0, rsp_valid_out, rsp_kind_out});
    chk("nak", (rsp == 3'h6) ? 16'h0009 : 16'h0000, {8'h00, rsp_nak_code_out});
  endtask
  // Mask bits: grant, refuse, store nak, program exit
  task automatic wr(input logic [1:0] k, input logic [15:0] a, input logic [3:0] m,
                    input logic [3:0] e);
    host_u.send_wr(k, a);
    chk("wr", {12'h0, e}, {12'h0, m & {wr_grant_out, wr_refuse_out, store_nak_out,
        prog_exit_out}});
    chk("status", (k == 2'h1 && e[0]) ? 16'h5000 : 16'h0000, status_set_out);
  endtask
  task automatic t_restore();
    @(posedge clock_in) #1;
    restore_in = 1'b1;
    restore_code_in = 16'h1234;
    restore_addr_in = 16'h0100;
    @(posedge clock_in) #1;
    restore_in = 1'b0;
    chk("first", 16'h0100, first_wr_out);
  endtask
  task automatic t_code();
    cmd(16'h1111, 16'h0200, 3'h6);
    chk("first", 16'h0100, first_wr_out);
    host_u.start_cmd(8'h21, 16'h1234, 16'h0200);
    host_u.end_cmd();
    chk("persist", 16'h8200, {persist_out, persist_addr_out[14:0]});
    chk("persist_fact", 16'h0001, {15'h0, persist_fact_out});
    chk("rsp", 16'h0004, {13'h0, rsp_valid_out, rsp_kind_out});
    chk("fact", 16'h0001, {15'h0, fact_prot_out});
  endtask
  task automatic t_writes();
    wr(2'h0, 16'h01FF, 4'hC, 4'h4);
    wr(2'h0, 16'h0200, 4'hC, 4'h8);
    wr(2'h1, 16'h0000, 4'h9, 4'h1);
    wr(2'h1, 16'h0300, 4'h9, 4'h8);
    wr(2'h2, 16'h0010, 4'hA, 4'h2);
    wr(2'h0, 16'hFF00, 4'hC, 4'h4);
    wr(2'h0, 16'hFEFF, 4'hC, 4'h8);
  endtask
  task automatic t_busy_and_other();
    busy_in = 1'b1;
    cmd(16'h1234, 16'h0000, 3'h5);
    busy_in = 1'b0;
    chk("first", 16'h0200, first_wr_out);
    host_u.start_cmd(8'h20, 16'h1234, 16'h0000);
    host_u.end_cmd();
    chk("ignored", 16'h0200, rsp_valid_out ? 16'hFFFF : first_wr_out);
  endtask
  task automatic t_all_and_clear();
    cmd(16'h1234, 16'hFFFF, 3'h4);
    wr(2'h0, 16'hFFFE, 4'hC, 4'h4);
    host_u.start_cmd(8'h21, 16'h1234, 16'h0000);
    host_u.end_cmd();
    chk("persist", 16'h8000, {persist_out, persist_code_out[14:0]});
    chk("first", 16'h0000, first_wr_out);
    cmd(16'h7777, 16'h0300, 3'h4);
    cmd(16'h1234, 16'h0000, 3'h6);
    // Unprotect with the matching code before a store
    cmd(16'h7777, 16'h0000, 3'h4);
    wr(2'h2, 16'h0010, 4'hA, 4'h8);
  endtask
  // Fresh reset, no restore: both-zero command touches only the factory block
  task automatic t_zero();
    srst_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1 srst_in = 1'b0;
    chk("fact", 16'h0000, {15'h0, fact_prot_out});
    cmd(16'h0000, 16'h0000, 3'h4);
    chk("state", 16'h8000, {fact_prot_out, first_wr_out[14:0]});
    wr(2'h0, 16'h0000, 4'hC, 4'h8);
    wr(2'h0, 16'hFF00, 4'hC, 4'h4);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    #1 srst_in = 1'b0;
    chk("first", 16'h0000, first_wr_out);
    t_restore();
    t_code();
    t_writes();
    t_busy_and_other();
    t_all_and_clear();
    t_zero();
    report_and_stop();
  end
  // About 50 cycles expected; cut a hang well past that
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
endmodule
